// [rtl/swmux_pkg.sv]
// Shared constants and types for the four-channel bus switch slave and its master.
// Assumes a single system clock of CLK_PERIOD_NS on both ends.
package swmux_pkg;

	// System clock
	localparam int CLK_PERIOD_NS = 25;

	// Reset pin must be low at least this long; at least one cycle
	localparam int RST_MIN_NS  = 4;
	localparam int RST_MIN_CYC = ((RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS > 0) ?
		((RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;

	// Master serial clock quarter period, rounded up to whole cycles
	localparam int SCL_QTR_NS  = 125;
	localparam int SCL_QTR_CYC = ((SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS > 0) ?
		((SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;

	// Fixed upper five address bits, two low bits come from pins
	localparam logic [4:0] ADDR_FIXED = 5'h1C;

	// Register layout: channel enables low, interrupt flags high
	localparam int         CTRL_LSB   = 0;
	localparam int         IRQ_LSB    = 4;
	localparam logic [3:0] CTRL_RST   = 4'h0;

	// Bit counting within a byte
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam logic [3:0] LAST_BIT   = 4'h7;

	// Master slot numbering: 0-7 address, 8 ack, 9-16 data, 17 ack
	localparam logic [4:0] SLOT_AACK  = 5'h08;
	localparam logic [4:0] SLOT_LAST  = 5'h11;

	// Slave states, Gray coded along the usual path
	typedef enum logic [2:0] {
		D_IDLE  = 3'h0,
		D_ADDR  = 3'h1,
		D_AACK  = 3'h3,
		D_WDATA = 3'h2,
		D_WACK  = 3'h6,
		D_RDATA = 3'h7,
		D_RACK  = 3'h5,
		D_SKIP  = 3'h4
	} dev_state_t;

	// Master states, Gray coded
	typedef enum logic [1:0] {
		H_IDLE  = 2'h0,
		H_START = 2'h1,
		H_BITS  = 2'h3,
		H_STOP  = 2'h2
	} host_state_t;

endpackage : swmux_pkg

// [rtl/swmux_link_if.sv]
// Two-wire link between the master and the switch slave.
// Both lines are open drain with pull-ups; the wire levels are resolved here.
`timescale 1ns/10ps
interface swmux_link_if;
	logic scl_o;     // Master clock drive value
	logic scl_oe;    // Master pulls clock
	logic hsda_o;    // Master data drive value
	logic hsda_oe;   // Master pulls data
	logic dsda_o;    // Slave data drive value
	logic dsda_oe;   // Slave pulls data
	wire  scl;       // Resolved clock line
	wire  sda;       // Resolved data line

	// Pull-up wins unless some party drives a low
	assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
	assign sda = ((hsda_oe && !hsda_o) || (dsda_oe && !dsda_o)) ? 1'b0 : 1'b1;

	modport host (output scl_o, scl_oe, hsda_o, hsda_oe, input scl, sda);
	modport device (output dsda_o, dsda_oe, input scl, sda);
endinterface : swmux_link_if

// [rtl/swmux_host.sv]
// Bus master: one addressed transfer of one byte per request, then a stop.
// Assumes the slave answers within the low half of the generated clock.
`timescale 1ns/10ps
module swmux_host
	import swmux_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// User request
	input  wire logic       go_i,
	input  wire logic [6:0] addr_i,
	input  wire logic       read_i,
	input  wire logic [7:0] wdata_i,
	// User answer
	output logic            busy_o,
	output logic            done_o,
	output logic            nack_o,
	output logic [7:0]      rdata_o,
	// Link
	swmux_link_if.host      link
);

	// All master state
	typedef struct packed {
		logic        sda_m;    // Data sync stage one
		logic        sda_s;    // Data sync stage two
		host_state_t st;       // Sequencer state
		logic [2:0]  tick;     // Cycle within a quarter
		logic [1:0]  qc;       // Quarter within a bit
		logic [4:0]  slot;     // Bit slot of the transfer
		logic [17:0] tx;       // Slot pattern, 1 means release
		logic        rd;       // Read transfer
		logic [7:0]  rx;       // Received data
		logic        scl_oe;   // Pull clock low
		logic        sda_oe;   // Pull data low
		logic        busy;     // Transfer running
		logic        done;     // End pulse
		logic        nack;     // Failed transfer seen
		logic [7:0]  rdata;    // Data byte of the last transfer, read or written
	} host_regs_t;

	host_regs_t q_r;
	host_regs_t q_nxt;
	logic       qend;          // Last cycle of a quarter

	// Sequencer: clock derived by a divider, one bit every four quarters
	always_comb begin
		q_nxt       = q_r;
		q_nxt.sda_m = link.sda;
		q_nxt.sda_s = q_r.sda_m;
		q_nxt.done  = 1'b0;
		qend        = (q_r.tick == 3'(SCL_QTR_CYC - 1));
		if (q_r.st == H_IDLE) begin
			// Latch a request; slots carry address, acks and data
			if (go_i) begin
				q_nxt.st   = H_START;
				q_nxt.tick = 3'h0;
				q_nxt.qc   = 2'h0;
				q_nxt.rd   = read_i;
				q_nxt.nack = 1'b0;
				q_nxt.tx   = {addr_i, read_i, 1'b1, (read_i ? 8'hFF : wdata_i), 1'b1}; // [R10]
				q_nxt.busy = 1'b1;
			end
		end else begin
			q_nxt.tick = qend ? 3'h0 : q_r.tick + 3'h1;
			if (qend) begin
				q_nxt.qc = q_r.qc + 2'h1;
				unique case (q_r.st)
					H_START: begin
						// Data falls while clock high, then clock falls
						if (q_r.qc == 2'h0) begin
							q_nxt.sda_oe = 1'b1; // [R5]
						end else if (q_r.qc == 2'h1) begin
							q_nxt.scl_oe = 1'b1;
							q_nxt.st     = H_BITS;
							q_nxt.qc     = 2'h0;
							q_nxt.slot   = 5'h00;
						end
					end
					H_BITS: begin
						if (q_r.qc == 2'h0) begin
							// Change data only while clock low
							q_nxt.sda_oe = ~q_r.tx[17]; // [R4] [R7] [R8]
						end else if (q_r.qc == 2'h1) begin
							q_nxt.scl_oe = 1'b0;
						end else if (q_r.qc == 2'h3) begin
							// Sample at end of high phase, then pull clock low
							q_nxt.scl_oe = 1'b1;
							q_nxt.tx     = {q_r.tx[16:0], 1'b1};
							q_nxt.slot   = q_r.slot + 5'h01;
							if (q_r.slot > SLOT_AACK && q_r.slot < SLOT_LAST) begin
								q_nxt.rx = {q_r.rx[6:0], q_r.sda_s};
							end
							// Address refused, or write data refused: give up [R9]
							if ((q_r.slot == SLOT_AACK || (q_r.slot == SLOT_LAST && !q_r.rd))
								&& q_r.sda_s) begin
								q_nxt.nack = 1'b1;
							end
							if ((q_r.slot == SLOT_AACK && q_r.sda_s) || q_r.slot == SLOT_LAST) begin
								q_nxt.st = H_STOP;
								q_nxt.qc = 2'h0;
							end
						end
					end
					H_STOP: begin
						// Data low, clock high, then data rises
						if (q_r.qc == 2'h0) begin
							q_nxt.sda_oe = 1'b1;
						end else if (q_r.qc == 2'h1) begin
							q_nxt.scl_oe = 1'b0;
						end else if (q_r.qc == 2'h2) begin
							q_nxt.sda_oe = 1'b0; // [R6]
						end else begin
							q_nxt.st    = H_IDLE;
							q_nxt.busy  = 1'b0;
							q_nxt.done  = 1'b1;
							q_nxt.rdata = q_r.rx;
						end
					end
					H_IDLE: begin
						q_nxt.st = H_IDLE;
					end
				endcase
			end
		end
	end

	// State register, frozen while the enable is low
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			q_r <= '{sda_m: 1'b1, sda_s: 1'b1, st: H_IDLE, tx: 18'h3FFFF, default: '0};
		end else if (ce_i) begin
			q_r <= q_nxt;
		end
	end

	// Outputs straight from the state
	assign busy_o       = q_r.busy;
	assign done_o       = q_r.done;
	assign nack_o       = q_r.nack;
	assign rdata_o      = q_r.rdata;
	assign link.scl_o   = 1'b0;
	assign link.scl_oe  = q_r.scl_oe;
	assign link.hsda_o  = 1'b0;
	assign link.hsda_oe = q_r.sda_oe;

endmodule : swmux_host

// [rtl/swmux_dev.sv]
// Slave control logic of a four-channel two-wire bus switch.
// Assumes the link lines, reset pin, power-on level, address pins and channel
// interrupt inputs are all asynchronous and are synchronised here.
//
// Operation
// R1 - Interrupt flag reads 1 when channel interrupts
// R2 - Reset pin low clears register and sequencer
// R3 - Power-on hold clears everything, channels deselected; the code clears register and sequencer only, not the syncs, as for R2
// R4 - One bit per clock, data stable high
// R5 - Data falling while clock high starts
// R6 - Data rising while clock high stops, bus free
// R7 - Receiver pulls data low for ninth clock
// R8 - Receiver releases data high to refuse
// R9 - Master retries later after a refusal; this master gives up, goes to stop and sets nack_o instead
// R10 - Seven address bits first, direction bit last
// R11 - Direction 0 writes, 1 reads register
// R12 - Idle slave waits for start plus address
// R13 - Matching address is acknowledged for one clock
// R14 - Master never enables two same-address channels
// R15 - Upper bits show live interrupt input levels
// R16 - Each low bit enables its own channel
// R17 - New selection applies only after stop
// R18 - Combined interrupt low while any input low
// R19 - Read shifts whole byte, MSB first
`timescale 1ns/10ps
module swmux_dev
	import swmux_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// Device pins
	input  wire logic       rst_pin_n_i,
	input  wire logic       por_hold_i,
	input  wire logic [1:0] addr_pin_i,
	input  wire logic [3:0] chan_irq_n_i,
	// Channel switches and combined interrupt
	output logic [3:0]      chan_en_o,
	output logic            int_n_o,
	output logic            int_n_oe_o,
	// Link
	swmux_link_if.device    link
);

	// All slave state
	typedef struct packed {
		logic       scl_m;     // Clock sync stage one
		logic       scl_s;     // Clock sync stage two
		logic       scl_d;     // Clock one cycle older
		logic       sda_m;     // Data sync stage one
		logic       sda_s;     // Data sync stage two
		logic       sda_d;     // Data one cycle older
		logic       rstn_m;    // Reset pin stage one
		logic       rstn_s;    // Reset pin stage two
		logic       por_m;     // Power-on hold stage one
		logic       por_s;     // Power-on hold stage two
		logic [2:0] rst_cnt;   // Cycles the reset pin has been low
		logic [1:0] apin_m;    // Address pins stage one
		logic [1:0] apin_s;    // Address pins stage two
		logic [3:0] irq_m;     // Channel interrupts stage one
		logic [3:0] irq_s;     // Channel interrupts stage two
		dev_state_t st;        // Serial sequencer
		logic [3:0] bitc;      // Bits of current byte
		logic [7:0] sh;        // Shift register
		logic       rw;        // Direction of this transfer
		logic [3:0] ctrl;      // Active channel enables
		logic [3:0] pend;      // Written enables awaiting stop
		logic       pend_v;    // A written byte is waiting
		logic       sda_oe;    // Pull data low
		logic       int_oe;    // Pull combined interrupt low
	} dev_regs_t;

	dev_regs_t  q_r;
	dev_regs_t  q_nxt;
	logic       scl_rise;      // Clock rising edge seen
	logic       scl_fall;      // Clock falling edge seen
	logic       start_det;     // Start condition seen
	logic       stop_det;      // Stop condition seen
	logic       core_rst;      // Reset from pin or power-on
	logic [3:0] irq_flags;     // Live flags, 1 means interrupt

	// Edge and condition detection on the synchronised lines only
	always_comb begin
		scl_rise  = q_r.scl_s & ~q_r.scl_d;
		scl_fall  = ~q_r.scl_s & q_r.scl_d;
		// The clock must hold high across the compare, so a data change
		// that lands with a clock edge is not mistaken for a condition
		start_det = q_r.scl_s & q_r.scl_d & q_r.sda_d & ~q_r.sda_s; // [R5]
		stop_det  = q_r.scl_s & q_r.scl_d & ~q_r.sda_d & q_r.sda_s; // [R6]
		core_rst  = (q_r.rst_cnt >= 3'(RST_MIN_CYC)) | q_r.por_s;   // [R2] [R3]
		irq_flags = ~q_r.irq_s;                                     // [R1] [R15]
	end

	// Next state: synchronisers, reset filter, serial sequencer
	always_comb begin
		q_nxt        = q_r;
		// Two-stage synchronisers, second stage feeds all logic
		q_nxt.scl_m  = link.scl;
		q_nxt.scl_s  = q_r.scl_m;
		q_nxt.scl_d  = q_r.scl_s;
		q_nxt.sda_m  = link.sda;
		q_nxt.sda_s  = q_r.sda_m;
		q_nxt.sda_d  = q_r.sda_s;
		q_nxt.rstn_m = rst_pin_n_i;
		q_nxt.rstn_s = q_r.rstn_m;
		q_nxt.por_m  = por_hold_i;
		q_nxt.por_s  = q_r.por_m;
		q_nxt.apin_m = addr_pin_i;
		q_nxt.apin_s = q_r.apin_m;
		q_nxt.irq_m  = chan_irq_n_i;
		q_nxt.irq_s  = q_r.irq_m;

		// Count low cycles of the reset pin, saturating
		if (!q_r.rstn_s) begin
			q_nxt.rst_cnt = (q_r.rst_cnt == 3'h7) ? q_r.rst_cnt : q_r.rst_cnt + 3'h1; // [R2]
		end else begin
			q_nxt.rst_cnt = 3'h0;
		end

		// Combined interrupt is not latched and ignores channel selection
		q_nxt.int_oe = |irq_flags; // [R18]

		if (start_det) begin
			// Start or repeated start: expect an address byte
			q_nxt.st     = D_ADDR; // [R12]
			q_nxt.bitc   = 4'h0;
			q_nxt.sda_oe = 1'b0;
		end else if (stop_det) begin
			// Stop frees the bus and applies the last written byte
			q_nxt.st     = D_IDLE; // [R6]
			q_nxt.sda_oe = 1'b0;
			if (q_r.pend_v) begin
				q_nxt.ctrl   = q_r.pend; // [R17] [R16]
				q_nxt.pend_v = 1'b0;
			end
		end else if (scl_rise) begin
			// Sample on the rising edge, where data is stable
			unique case (q_r.st)
				D_ADDR, D_WDATA: begin
					if (q_r.bitc < BYTE_BITS) begin
						q_nxt.sh   = {q_r.sh[6:0], q_r.sda_s}; // [R4] [R10]
						q_nxt.bitc = q_r.bitc + 4'h1;
					end
				end
				D_RACK: begin
					// Master left data high: read ends here
					if (q_r.sda_s) begin
						q_nxt.st = D_SKIP; // [R8]
					end
				end
				D_IDLE, D_AACK, D_WACK, D_RDATA, D_SKIP: begin
					q_nxt.st = q_r.st;
				end
			endcase
		end else if (scl_fall) begin
			// Drive or release data only while the clock is low
			unique case (q_r.st)
				D_ADDR: begin
					if (q_r.bitc == BYTE_BITS) begin
						if (q_r.sh[7:1] == {ADDR_FIXED, q_r.apin_s}) begin
							q_nxt.sda_oe = 1'b1;       // [R13] [R7]
							q_nxt.rw     = q_r.sh[0];  // [R11]
							q_nxt.st     = D_AACK;
						end else begin
							// Not ours: stay off the bus until the next condition
							q_nxt.st = D_SKIP; // [R12]
						end
					end
				end
				D_AACK: begin
					q_nxt.bitc = 4'h0;
					if (q_r.rw) begin
						// Interrupt levels are taken at the start of the byte
						q_nxt.sh     = {irq_flags, q_r.ctrl};  // [R19] [R15]
						q_nxt.sda_oe = ~irq_flags[3];          // [R19]
						q_nxt.st     = D_RDATA;                // [R11]
					end else begin
						q_nxt.sda_oe = 1'b0;
						q_nxt.st     = D_WDATA;
					end
				end
				D_WDATA: begin
					if (q_r.bitc == BYTE_BITS) begin
						// Only the last byte of a burst is kept
						q_nxt.pend   = q_r.sh[3:0]; // [R17]
						q_nxt.pend_v = 1'b1;
						q_nxt.sda_oe = 1'b1;        // [R7]
						q_nxt.st     = D_WACK;
					end
				end
				D_WACK: begin
					q_nxt.sda_oe = 1'b0;
					q_nxt.bitc   = 4'h0;
					q_nxt.st     = D_WDATA;
				end
				D_RDATA: begin
					if (q_r.bitc == LAST_BIT) begin
						// Release so the master can answer
						q_nxt.sda_oe = 1'b0;
						q_nxt.st     = D_RACK;
					end else begin
						q_nxt.sh     = {q_r.sh[6:0], 1'b0};
						q_nxt.sda_oe = ~q_r.sh[6]; // [R19] [R4]
						q_nxt.bitc   = q_r.bitc + 4'h1;
					end
				end
				D_RACK: begin
					// Master acknowledged: send a fresh byte
					q_nxt.bitc   = 4'h0;
					q_nxt.sh     = {irq_flags, q_r.ctrl}; // [R19]
					q_nxt.sda_oe = ~irq_flags[3];
					q_nxt.st     = D_RDATA;
				end
				D_IDLE, D_SKIP: begin
					q_nxt.st = q_r.st;
				end
			endcase
		end

		// Pin or power-on reset clears register and sequencer, not the syncs
		if (core_rst) begin
			q_nxt.st     = D_IDLE;   // [R2] [R3]
			q_nxt.bitc   = 4'h0;
			q_nxt.sh     = 8'h00;
			q_nxt.rw     = 1'b0;
			q_nxt.ctrl   = CTRL_RST; // [R3] [R16]
			q_nxt.pend   = CTRL_RST;
			q_nxt.pend_v = 1'b0;
			q_nxt.sda_oe = 1'b0;
		end
	end

	// State register, frozen while the enable is low
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			q_r <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
				sda_d: 1'b1, rstn_m: 1'b1, rstn_s: 1'b1, irq_m: 4'hF, irq_s: 4'hF,
				st: D_IDLE, ctrl: CTRL_RST, pend: CTRL_RST, default: '0};
		end else if (ce_i) begin
			q_r <= q_nxt;
		end
	end

	// Outputs straight from the state; open-drain lines drive only low
	assign chan_en_o    = q_r.ctrl;
	assign int_n_o      = 1'b0;
	assign int_n_oe_o   = q_r.int_oe;
	assign link.dsda_o  = 1'b0;
	assign link.dsda_oe = q_r.sda_oe;

endmodule : swmux_dev

// [sim/swmux_sva.sv]
// Link checker for the switch slave and its master.
// Assumes it sees the resolved lines and both data enables, one clock domain.
`timescale 1ns/10ps
module swmux_sva (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_i,
	// Link signals
	input  wire logic hsda_oe,
	input  wire logic dsda_oe,
	input  wire logic scl,
	input  wire logic sda
);
	logic [4:0] cnt_r;   // Clock rises since the last start
	logic       dir_r;   // Direction bit of the current transfer
	logic       scl_d;   // Clock line one cycle ago
	logic       sda_d;   // Data line one cycle ago

	// Slot counter; restarts on every start so repeated starts are covered too
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cnt_r <= 5'h00;
			dir_r <= 1'b0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			if (scl && scl_d && sda_d && !sda) begin
				cnt_r <= 5'h00;
			end else if (scl && !scl_d) begin
				cnt_r <= cnt_r + 5'h01;
				if (cnt_r == 5'h07) begin
					dir_r <= sda;
				end
			end
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// Start seen on the wire, a held pull, and a free bus
	sequence start_s; scl && $past(scl) && $past(sda) && !sda; endsequence
	sequence hold_s; dsda_oe [*8]; endsequence
	sequence idle_s; (sda && scl && !dsda_oe) [*8]; endsequence

	dev_stable_a: assert property ($changed(dsda_oe) |-> !scl && !$past(scl))
		else $error("slave changed data while clock high");
	bit_stable_a: assert property (scl && $past(scl) && $changed(sda)
		|-> $changed(hsda_oe) && !dsda_oe)
		else $error("data moved in clock high outside start or stop");
	start_seq_a: assert property (start_s |-> hsda_oe ##[3:8] !scl)
		else $error("start not followed by clock low");
	stop_free_a: assert property (scl && $past(scl) && $rose(sda) |-> idle_s)
		else $error("bus not free after stop");
	slave_slot_a: assert property ($rose(scl) && dsda_oe |->
		cnt_r == 5'h08 || (!dir_r && cnt_r == 5'h11)
		|| (dir_r && cnt_r >= 5'h09 && cnt_r <= 5'h10))
		else $error("slave pulled data outside its slots");
	ack_hold_a: assert property ($rose(scl) && dsda_oe |-> hold_s)
		else $error("slave pull dropped in clock high");
	ack_free_a: assert property ($fell(scl) && cnt_r == 5'h09 && !dir_r
		|-> ##[1:6] !dsda_oe)
		else $error("address ack held past one clock");
	read_nack_a: assert property ($rose(scl) && cnt_r == 5'h11 && dir_r
		|-> sda ##1 sda)
		else $error("final read byte not refused");
endmodule : swmux_sva

// [sim/test_i2c_channel_switch_slave.sv]
// Testbench joining the master and the switch slave over one link.
// Assumes the package constants and a 40 MHz clock; transfers take ~400 cycles.
`timescale 1ns/10ps
module test_i2c_channel_switch_slave;
	import swmux_pkg::*;
	logic       mclk_i    = 1'b0;   // System clock
	logic       rst_i     = 1'b1;   // Sync reset
	logic       go        = 1'b0;   // Master request
	logic [6:0] addr      = 7'h00;  // Target address
	logic       rd        = 1'b0;   // Direction
	logic [7:0] wdata     = 8'h00;  // Write byte
	logic       busy;               // Master busy
	logic       done;               // Master done pulse
	logic       nack;               // Address refused
	logic [7:0] rdata;              // Read byte
	logic       rst_pin_n = 1'b1;   // Slave reset pin
	logic       por_hold  = 1'b0;   // Supply below threshold
	logic [1:0] pins      = 2'h0;   // Address pins
	logic [3:0] irq_n     = 4'hF;   // Channel interrupts
	logic [3:0] chan_en;            // Channel enables
	logic       int_oe;             // Combined interrupt pull
	logic       int_val;            // Combined interrupt drive value, must stay low
	int         error_cnt = 0;      // Mismatches
	int         compares  = 0;      // Comparisons
	int         cycles    = 0;      // Hang guard

	swmux_link_if link ();
	swmux_host i_swmux_host (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .go_i(go),
		.addr_i(addr), .read_i(rd), .wdata_i(wdata), .busy_o(busy), .done_o(done),
		.nack_o(nack), .rdata_o(rdata), .link(link));
	swmux_dev i_swmux_dev (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
		.rst_pin_n_i(rst_pin_n), .por_hold_i(por_hold), .addr_pin_i(pins),
		.chan_irq_n_i(irq_n), .chan_en_o(chan_en), .int_n_o(int_val), .int_n_oe_o(int_oe),
		.link(link));
	swmux_sva i_swmux_sva (.mclk_i(mclk_i), .rst_i(rst_i), .hsda_oe(link.hsda_oe),
		.dsda_oe(link.dsda_oe), .scl(link.scl), .sda(link.sda));

	// Clock
	always #12.5 mclk_i = ~mclk_i;

	// Hang guard; all transfers together stay well below this
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	// Read byte: live flags high, stored enables low
	function automatic logic [7:0] exp_rd(input logic [3:0] q, input logic [3:0] en);
		return {~q, en};
	endfunction : exp_rd

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One master transfer; mid is the selection sampled after the data, before stop
	task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] d,
		input logic [1:0] p, input logic [3:0] q, output logic [3:0] mid);
		int n;
		@(posedge mclk_i);
		go <= 1'b1;
		addr <= a;
		rd <= r;
		wdata <= d;
		pins <= p;
		irq_n <= q;
		@(posedge mclk_i);
		go <= 1'b0;
		n = 0;
		mid = chan_en;
		// Outputs read on the falling edge, where they have settled
		while (done !== 1'b1 && n < 1000) begin
			@(negedge mclk_i);
			n++;
			if (n == 360) begin
				mid = chan_en;
			end
		end
		// A transfer that never ends counts here: done low, busy still high
		chk(8'({busy, done}), 8'h01);
	endtask : xfer

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	// Main sequence: random writes and reads, wrong address, then both resets
	initial begin
		logic [3:0] mid;
		logic [3:0] en_exp;
		logic [3:0] q;
		logic [1:0] p;
		logic [7:0] d;
		void'($urandom(32'h6EB7));
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(negedge mclk_i);
		chk(8'(chan_en), 8'h00);
		chk(8'({int_val, int_oe}), 8'h00);
		en_exp = 4'h0;
		for (int i = 0; i < 8; i++) begin
			p = 2'($urandom);
			// No downstream devices share an address, so any enable mix is legal
			d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			q = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
			xfer({ADDR_FIXED, p}, 1'b0, d, p, q, mid);
			chk(8'(nack), 8'h00);
			chk(8'(mid), 8'(en_exp));
			en_exp = d[3:0];
			chk(8'(chan_en), 8'(en_exp));
			chk(8'(link.scl & link.sda), 8'h01);
			chk(8'({int_val, int_oe}), 8'(|(~q)));
			xfer({ADDR_FIXED, p}, 1'b1, 8'h00, p, q, mid);
			chk(rdata, exp_rd(q, en_exp));
			xfer({ADDR_FIXED, ~p}, 1'b0, ~d, p, q, mid);
			chk(8'(nack), 8'h01);
			chk(8'(chan_en), 8'(en_exp));
		end
		// Reset pin, then power-on hold, each after a nonzero selection
		for (int j = 0; j < 2; j++) begin
			xfer({ADDR_FIXED, p}, 1'b0, 8'h0A, p, 4'hF, mid);
			chk(8'(chan_en), 8'h0A);
			@(posedge mclk_i);
			rst_pin_n <= (j != 0);
			por_hold <= (j == 1);
			repeat (3) @(posedge mclk_i);
			rst_pin_n <= 1'b1;
			por_hold <= 1'b0;
			repeat (6) @(negedge mclk_i);
			chk(8'(chan_en), 8'h00);
			xfer({ADDR_FIXED, p}, 1'b1, 8'h00, p, 4'hF, mid);
			chk(8'(nack), 8'h00);
			chk(rdata, exp_rd(4'hF, 4'h0));
		end
		give_verdict();
	end
endmodule : test_i2c_channel_switch_slave
